// file: dv/fsu_flash_model.sv
// behavioural flash model answering the sector unprotect flow
`timescale 1ns/10ps
module fsu_flash_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // flash pins
  input wire logic [19:0] flash_addr,
  input wire logic [7:0] flash_dout,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_byte_n,
  input wire logic wp_n,
  output logic [7:0] flash_din,
  // bench control and observation
  input wire logic slow,
  output logic [15:0] seen_mask,
  output logic byte_seen,
  output logic ready,
  output int errs
);
  logic we_q;
  logic [7:0] last;
  int st;
  int gap;
  int wait_c;
  logic [14:0] ca [5] = '{15'h5555, 15'h2AAA, 15'h5555, 15'h5555, 15'h2AAA};
  logic [7:0] cd [5] = '{8'hAA, 8'h55, 8'h60, 8'hAA, 8'h55};
  // status bit on read
  // released bus shows the inverse so a stale value never passes
  assign flash_din = (!flash_ce_n && !flash_oe_n) ? {ready, 7'h00} : ~last;
  always @(posedge core_clk) begin
    we_q <= flash_we_n;
    gap <= gap + 1;
    if (wait_c > 0) wait_c <= wait_c - 1;
    if (wait_c == 1) ready <= 1'b1;
    if (!flash_ce_n && !flash_oe_n) last <= {ready, 7'h00};
    if (!nrst) begin
      st <= 0;
      ready <= 1'b1;
      wait_c <= 0;
      errs <= 0;
      seen_mask <= '0;
      byte_seen <= 1'b1;
      last <= 8'h00;
    end else if (we_q && !flash_we_n) begin
      gap <= 0;
      if (st == 2) byte_seen <= flash_byte_n;
      // load spacing, no write while busy
      if (!ready || (st == 5 && (gap < 2 || gap > 299))) errs <= errs + 1;
    end else if (!we_q && flash_we_n) begin
      if (st < 5) begin
        // unlock and setup on low bits
        if (flash_addr[14:0] !== ca[st] || flash_dout !== cd[st]) errs <= errs + 1;
        if (st == 0) seen_mask <= '0;
        st <= st + 1;
      end else begin
        // sector on top bits, B0 ends list
        if (wp_n) seen_mask[flash_addr[19:16]] <= 1'b1;
        if (flash_dout === 8'hB0) begin
          st <= 0;
          ready <= 1'b0;
          wait_c <= slow ? 60 : 2;
        end else if (flash_dout !== 8'h40) begin
          errs <= errs + 1;
        end
      end
    end
  end
endmodule

// file: dv/fsu_host_tb.sv
// self-checking bench for the sector unprotect host sequencer
`timescale 1ns/10ps
module fsu_host_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic [15:0] sector_mask = '0;
  logic word_mode = 1'b1;
  logic slow = 1'b0;
  logic wp_n = 1'b1;
  logic busy, done, dout_oe, ce_n, we_n, oe_n, byte_n, ready, byte_seen;
  logic [19:0] addr;
  logic [7:0] dout, din;
  logic [15:0] seen_mask;
  int errs;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #50 core_clk = ~core_clk;
  fsu_host u_fsu_host (.core_clk(core_clk), .nrst(nrst), .start(start),
    .sector_mask(sector_mask), .word_mode(word_mode), .busy(busy), .done(done),
    .flash_addr(addr), .flash_dout(dout), .flash_dout_oe(dout_oe), .flash_din(din),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_byte_n(byte_n));
  fsu_flash_model u_fsu_flash_model (.core_clk(core_clk), .nrst(nrst), .flash_addr(addr),
    .flash_dout(dout), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_byte_n(byte_n), .wp_n(wp_n), .flash_din(din), .slow(slow),
    .seen_mask(seen_mask), .byte_seen(byte_seen), .ready(ready), .errs(errs));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a zero mask must leave the bus idle
  task automatic zero_mask();
    @(negedge core_clk);
    start = 1'b1;
    repeat (6) @(negedge core_clk);
    start = 1'b0;
    check({busy, we_n, ce_n}, 3'b011);
  endtask
  // full sequence with a second start poked in mid-run
  task automatic run(input logic [15:0] m, input logic wm, input logic sl);
    int n;
    @(negedge core_clk);
    sector_mask = m;
    word_mode = wm;
    slow = sl;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    check(busy, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
      start = (n == 10);
      sector_mask = (n == 10) ? ~m : m;
    end
    check(n < 3000, 1'b1);
    check(ready, 1'b1);
    check(seen_mask, m & {16{wp_n}});
    check(byte_seen, wm);
    check(errs, 0);
    @(negedge core_clk);
    check({done, busy}, 2'b00);
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    zero_mask();
    run(16'h0001, 1'b1, 1'b0);
    run(16'h8000, 1'b0, 1'b1);
    run(16'hA5A5, 1'b1, 1'b1);
    // retry carries only the failed sectors
    run(16'h0420, 1'b1, 1'b0);
    run(16'hFFFF, 1'b0, 1'b0);
    wp_n = 1'b0;
    run(16'h0033, 1'b1, 1'b0);
    results();
  end
  // hang guard well above the longest run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
endmodule

// file: rtl/fsu_host.sv
// host sequencer that drives the flash sector unprotect command flow
//
// Operation
// - unlock AA@5555, 55@2AAA, then 60@5555 forms the setup command
// - second unlock, then 40 written at the first sector address (B0 if it is the only one)
// - every further selected sector except the last is written with 40
// - the last selected sector is written with B0, starting the operation
// - poll the status register until bit 7 reads one
// - only sectors that failed verify are loaded on a retry
// - protect allows one sector per sequence
// - width select is sampled on third write; host holds it static
// - successive load cycles spaced 0.3 us to 30 us
`timescale 1ns/10ps
module fsu_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // user request
  input wire logic start,
  input wire logic [fsu_pkg::NUM_SECTORS-1:0] sector_mask,
  input wire logic word_mode,
  output logic busy,
  output logic done,
  // flash pins
  output logic [fsu_pkg::ADDR_BITS-1:0] flash_addr,
  output logic [7:0] flash_dout,
  output logic flash_dout_oe,
  input wire logic [7:0] flash_din,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_byte_n
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fsu_pkg::fsu_state_type state_r, state_nxt;
  logic [3:0] step_r, step_nxt;
  logic [fsu_pkg::NUM_SECTORS-1:0] pend_r, pend_nxt;
  logic [fsu_pkg::CNT_BITS-1:0] cnt_r, cnt_nxt;
  fsu_pkg::fsu_bus_type bus_r, bus_nxt;
  logic byte_n_r, byte_n_nxt;
  logic done_r, done_nxt;
  logic [7:0] din_s1_r, din_s2_r, din_s3_r;

  // lowest pending sector index
  function automatic logic [3:0] first_set(input logic [fsu_pkg::NUM_SECTORS-1:0] m);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = fsu_pkg::NUM_SECTORS - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // ---------------------------------------------------------------
  // input synchroniser: async flash data, three stages
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    din_s1_r <= flash_din;
    din_s2_r <= din_s1_r;
    din_s3_r <= din_s2_r;
  end

  logic [3:0] sec_idx;
  logic last_sec;
  assign sec_idx = first_set(pend_r);
  assign last_sec = (pend_r & (pend_r - 16'h0001)) == 16'h0000;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    pend_nxt = pend_r;
    cnt_nxt = cnt_r;
    bus_nxt = bus_r;
    byte_n_nxt = byte_n_r;
    done_nxt = 1'b0;
    unique case (state_r)
      fsu_pkg::FSU_IDLE: begin
        bus_nxt.ce_n = 1'b1;
        bus_nxt.we_n = 1'b1;
        bus_nxt.oe_n = 1'b1;
        bus_nxt.dout_oe = 1'b0;
        // caller mask lists only sectors still failing verify
        if (start && sector_mask != 16'h0000) begin
          pend_nxt = sector_mask;
          // width select latched once, held static
          byte_n_nxt = word_mode;
          step_nxt = 4'h0;
          state_nxt = fsu_pkg::FSU_WR_LOW;
          cnt_nxt = '0;
        end
      end
      fsu_pkg::FSU_WR_LOW: begin
        bus_nxt.ce_n = 1'b0;
        bus_nxt.we_n = 1'b0;
        bus_nxt.oe_n = 1'b1;
        bus_nxt.dout_oe = 1'b1;
        bus_nxt.addr = '0;
        unique case (step_r)
          4'h0: begin
            bus_nxt.addr[14:0] = fsu_pkg::CMD_ADDR_A;
            bus_nxt.dout = fsu_pkg::CMD_UNLOCK1;
          end
          4'h1: begin
            bus_nxt.addr[14:0] = fsu_pkg::CMD_ADDR_B;
            bus_nxt.dout = fsu_pkg::CMD_UNLOCK2;
          end
          // unprotect setup only, protect flow never issued
          4'h2: begin
            bus_nxt.addr[14:0] = fsu_pkg::CMD_ADDR_A;
            bus_nxt.dout = fsu_pkg::CMD_UNPROT_SETUP;
          end
          // second unlock, low address bits only
          4'h3: begin
            bus_nxt.addr[14:0] = fsu_pkg::CMD_ADDR_A;
            bus_nxt.dout = fsu_pkg::CMD_UNLOCK1;
          end
          4'h4: begin
            bus_nxt.addr[14:0] = fsu_pkg::CMD_ADDR_B;
            bus_nxt.dout = fsu_pkg::CMD_UNLOCK2;
          end
          default: begin
            // sector on top address bits; load or last
            bus_nxt.addr[fsu_pkg::SECTOR_LSB +: fsu_pkg::SECTOR_BITS] = sec_idx;
            bus_nxt.dout = last_sec ? fsu_pkg::CMD_SECTOR_LAST : fsu_pkg::CMD_SECTOR_LOAD;
          end
        endcase
        cnt_nxt = cnt_r + 9'h001;
        if (cnt_r >= 9'(fsu_pkg::WP_CYC)) begin
          bus_nxt.we_n = 1'b1;
          cnt_nxt = '0;
          state_nxt = fsu_pkg::FSU_WR_HIGH;
        end
      end
      fsu_pkg::FSU_WR_HIGH: begin
        bus_nxt.we_n = 1'b1;
        bus_nxt.ce_n = 1'b1;
        cnt_nxt = cnt_r + 9'h001;
        // sector load spacing kept well inside the window
        if ((step_r < 4'h5 && cnt_r >= 9'(fsu_pkg::WPH_CYC))
            || cnt_r >= 9'(fsu_pkg::LOAD_MIN_CYC)) begin
          cnt_nxt = '0;
          bus_nxt.dout_oe = 1'b0;
          if (step_r < 4'h5) begin
            step_nxt = step_r + 4'h1;
            state_nxt = fsu_pkg::FSU_WR_LOW;
          end else if (last_sec) begin
            pend_nxt = '0;
            state_nxt = fsu_pkg::FSU_RD_WAIT;
          end else begin
            pend_nxt[sec_idx] = 1'b0;
            state_nxt = fsu_pkg::FSU_WR_LOW;
          end
        end
      end
      fsu_pkg::FSU_RD_WAIT: begin
        // status read: outputs enabled, wait access plus sync latency
        bus_nxt.ce_n = 1'b0;
        bus_nxt.oe_n = 1'b0;
        bus_nxt.dout_oe = 1'b0;
        cnt_nxt = cnt_r + 9'h001;
        if (cnt_r >= 9'(fsu_pkg::SRA_CYC + 3)) begin
          cnt_nxt = '0;
          state_nxt = fsu_pkg::FSU_RD_SAMPLE;
        end
      end
      fsu_pkg::FSU_RD_SAMPLE: begin
        bus_nxt.ce_n = 1'b1;
        bus_nxt.oe_n = 1'b1;
        // stay polling, no other command while bit is zero
        if (din_s2_r == din_s3_r && din_s3_r[fsu_pkg::DONE_BIT]) begin
          state_nxt = fsu_pkg::FSU_DONE;
        end else begin
          state_nxt = fsu_pkg::FSU_RD_WAIT;
        end
      end
      fsu_pkg::FSU_DONE: begin
        done_nxt = 1'b1;
        state_nxt = fsu_pkg::FSU_IDLE;
      end
      default: state_nxt = fsu_pkg::FSU_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= fsu_pkg::FSU_IDLE;
      step_r <= 4'h0;
      pend_r <= '0;
      cnt_r <= '0;
      bus_r <= '{addr: '0, dout: 8'h00, dout_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      byte_n_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      pend_r <= pend_nxt;
      cnt_r <= cnt_nxt;
      bus_r <= bus_nxt;
      byte_n_r <= byte_n_nxt;
      done_r <= done_nxt;
    end
  end

  assign flash_addr = bus_r.addr;
  assign flash_dout = bus_r.dout;
  assign flash_dout_oe = bus_r.dout_oe;
  assign flash_ce_n = bus_r.ce_n;
  assign flash_we_n = bus_r.we_n;
  assign flash_oe_n = bus_r.oe_n;
  assign flash_byte_n = byte_n_r;
  assign busy = state_r != fsu_pkg::FSU_IDLE;
  assign done = done_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_no_write_polling: assert property (@(posedge core_clk) disable iff (!nrst)
    !flash_oe_n |-> flash_we_n && !flash_dout_oe) else $error("write during status poll");
  a_width_static: assert property (@(posedge core_clk) disable iff (!nrst)
    busy && $past(busy) |-> $stable(flash_byte_n)) else $error("width select moved");
  a_cmd_high_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    !flash_we_n && step_r < 4'h5 |-> flash_addr[19:15] == 5'h00)
    else $error("command address high bits set");
  a_setup_data: assert property (@(posedge core_clk) disable iff (!nrst)
    !flash_we_n && step_r == 4'h2 |-> flash_dout == fsu_pkg::CMD_UNPROT_SETUP
    && flash_addr[14:0] == fsu_pkg::CMD_ADDR_A)
    else $error("bad setup command");
  a_sector_data: assert property (@(posedge core_clk) disable iff (!nrst)
    !flash_we_n && step_r == 4'h5 |-> flash_dout == fsu_pkg::CMD_SECTOR_LOAD
    || flash_dout == fsu_pkg::CMD_SECTOR_LAST)
    else $error("bad sector load data");
  a_data_driven: assert property (@(posedge core_clk) disable iff (!nrst)
    !flash_we_n |-> flash_dout_oe && !flash_ce_n && flash_oe_n)
    else $error("write strobe without driven data");
  a_last_goes_poll: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(flash_we_n) && flash_dout == fsu_pkg::CMD_SECTOR_LAST |-> ##[1:8] !flash_oe_n)
    else $error("no status poll after last load");
  a_load_spacing: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(flash_we_n) && step_r == 4'h5 |-> flash_we_n [*3]) else $error("load too close");
  a_done_after_bit: assert property (@(posedge core_clk) disable iff (!nrst)
    done |-> $past(din_s3_r[fsu_pkg::DONE_BIT], 2)) else $error("done without status bit");
endmodule

// file: rtl/fsu_pkg.sv
// package: constants and carriers for the flash sector unprotect host sequencer
package fsu_pkg;
  // ---------------------------------------------------------------
  // command addresses and data
  // ---------------------------------------------------------------
  localparam logic [14:0] CMD_ADDR_A = 15'h5555;
  localparam logic [14:0] CMD_ADDR_B = 15'h2AAA;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_UNPROT_SETUP = 8'h60;
  localparam logic [7:0] CMD_SECTOR_LOAD = 8'h40;
  localparam logic [7:0] CMD_SECTOR_LAST = 8'hB0;
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_BITS = 4;
  localparam int NUM_SECTORS = 16;
  localparam int ADDR_BITS = 20;
  localparam int DONE_BIT = 7;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int WP_NS = 60;
  localparam int WPH_NS = 50;
  localparam int LOAD_MIN_NS = 300;
  localparam int LOAD_MAX_NS = 30000;
  localparam int SRA_NS = 90;
  localparam int WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_MIN_CYC = (LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_MAX_CYC = LOAD_MAX_NS / CLK_PERIOD_NS;
  localparam int SRA_CYC = (SRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_BITS = 9;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] dout;
    logic dout_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } fsu_bus_type;
  typedef enum logic [2:0] {
    FSU_IDLE, FSU_WR_LOW, FSU_WR_HIGH, FSU_RD_WAIT, FSU_RD_SAMPLE, FSU_DONE
  } fsu_state_type;
endpackage
